// ### hw/bcp_pin_fire.sv
// Pin fire gating, punctuation ROM select, up-down scan counter and
// carrier-position simulator. Assumes a host that writes ports on
// hostReq and reads the request multiplexer bit, and optical pins.

module bcp_pin_fire
    import bcp_pkg::*;
(
    input  wire logic          clock,
    input  wire logic          rst_n,
    input  wire bcp_host_req_t hostReq,
    input  wire logic          carrierGoRight,
    input  wire logic          punctBackspace,
    input  wire bcp_sense_t    senseIn,
    input  wire logic [8:0]    romPinDriveLines,
    output logic [8:0]         pinFireGates_n,
    output logic               pinFireEnable_n,
    output logic               altRomSelect,
    output logic [2:0]         scanAddressLines,
    output logic [2:0]         punctRomAddr,
    output logic               requestMux,
    output logic               carrierError
);

    // ==========================================================
    // Synchronised inputs
    bcp_sense_t sense;

    bcp_sync u_sync
    (
        .clock   (clock),
        .rst_n   (rst_n),
        .asyncIn (senseIn),
        .syncOut (sense)
    );

    // ==========================================================
    // Edge detection on synchronised levels
    logic countPrev;
    logic printPrev;

    wire countStep  = sense.countPulse && !countPrev;
    wire printEdge  = sense.printPosPulse && !printPrev;

    // ==========================================================
    // Host port decode
    wire flagsWrite   = hostReq.wr && (hostReq.addr == BCP_FLAGS_PORT);
    wire printerLoad  = hostReq.wr && (hostReq.addr == BCP_PRINTER_PORT);

    logic betweenCharPunctFlag;
    logic printAllowed;
    logic hostDataBitOne;

    wire next_punct = flagsWrite ? hostReq.wdata[BCP_BIT_PUNCT] : betweenCharPunctFlag;
    wire next_allow = flagsWrite ? hostReq.wdata[BCP_BIT_ALLOW] : printAllowed;
    wire next_bitOne = flagsWrite ? hostReq.wdata[BCP_BIT_ROMSEL] : hostDataBitOne;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            betweenCharPunctFlag <= 1'b0;
            printAllowed         <= 1'b0;
            hostDataBitOne       <= 1'b0;
        end
        else
        begin
            betweenCharPunctFlag <= next_punct;
            printAllowed         <= next_allow;
            hostDataBitOne       <= next_bitOne;
        end
    end

    // ==========================================================
    // Up-down scan counter
    function automatic logic [3:0] presetFor(input logic right, input logic punct);
        logic [3:0] p;
        p = right ? BCP_PRESET_RIGHT : BCP_PRESET_LEFT;
        p[0] = right ^ punct;
        return p;
    endfunction

    function automatic logic [2:0] scanOf(input logic [3:0] q);
        return {q[3], q[2], q[1] ^ q[2]};
    endfunction

    logic [3:0] upDownCount;
    wire        presetNow = printerLoad || (flagsWrite && (next_punct != betweenCharPunctFlag));
    wire        presetPunct = printerLoad ? 1'b0 : next_punct;
    wire [3:0]  countStepped = carrierGoRight ? upDownCount - 4'h1 : upDownCount + 4'h1;
    wire [3:0]  next_upDownCount = presetNow ? presetFor(carrierGoRight, presetPunct)
                                 : countStep ? countStepped : upDownCount;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            upDownCount <= BCP_PRESET_LEFT;
        else
            upDownCount <= next_upDownCount;
    end

    wire [2:0] scanNow = scanOf(upDownCount);
    wire       counterLsb = upDownCount[0];
    wire       oddCountQualifier = carrierGoRight ^ counterLsb;

    // ==========================================================
    // Carrier-position simulator
    logic [3:0] simCount;
    wire        parallelLoad_n     = !sense.carrierPos;
    wire        countEnableTrickle = 1'b1;
    wire        masterClear_n      = 1'b1;
    wire        terminalCount      = countEnableTrickle && (simCount == BCP_SIM_TERMINAL);
    wire [3:0]  next_simCount = !masterClear_n ? 4'h0
                              : !parallelLoad_n ? BCP_SIM_PRESET
                              : (printEdge && !terminalCount) ? simCount + 4'h1
                              : simCount;
    // Early rise: terminal count seen while carrier still low
    wire        simulatedCarrier = sense.carrierPos || terminalCount;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            simCount <= BCP_SIM_PRESET;
        else
            simCount <= next_simCount;
    end

    // ==========================================================
    // Fire enable and pin gating
    wire fireOk = oddCountQualifier && printAllowed && sense.fireWindowOk;
    wire [8:0] romLines = betweenCharPunctFlag
                        ? {romPinDriveLines[8:1], 1'b0}
                        : romPinDriveLines;
    wire [8:0] pinBlock = {8'h00, betweenCharPunctFlag};
    wire [8:0] next_gates_n = fireOk ? ~(romLines & ~pinBlock) : 9'h1FF;
    wire       next_error = carrierError || (punctBackspace && sense.atEndStop);

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            countPrev        <= 1'b0;
            printPrev        <= 1'b0;
            pinFireGates_n   <= ~BCP_PINS_IDLE;
            pinFireEnable_n  <= 1'b1;
            altRomSelect     <= 1'b0;
            scanAddressLines <= 3'h0;
            punctRomAddr     <= 3'h0;
            requestMux       <= 1'b0;
            carrierError     <= 1'b0;
        end
        else
        begin
            countPrev        <= sense.countPulse;
            printPrev        <= sense.printPosPulse;
            pinFireGates_n   <= next_gates_n;
            pinFireEnable_n  <= !fireOk;
            altRomSelect     <= betweenCharPunctFlag;
            scanAddressLines <= scanNow;
            punctRomAddr     <= {scanNow[2], scanNow[1], hostDataBitOne};
            requestMux       <= simulatedCarrier;
            carrierError     <= next_error;
        end
    end

endmodule

// ### hw/bcp_pkg.sv
// Package for the in-between punctuation pin fire control block.
// Assumes a single 10 MHz clock domain and synchronous active-low reset.
package bcp_pkg;

    // ==========================================================
    // Host port numbers and data bit positions
    localparam logic [3:0] BCP_FLAGS_PORT    = 4'h3;
    localparam logic [3:0] BCP_PRINTER_PORT  = 4'h1;
    localparam int         BCP_BIT_PUNCT     = 4;
    localparam int         BCP_BIT_ALLOW     = 0;
    localparam int         BCP_BIT_ROMSEL    = 1;

    // ==========================================================
    // Up-down counter presets
    localparam logic [3:0] BCP_PRESET_RIGHT  = 4'hD;
    localparam logic [3:0] BCP_PRESET_LEFT   = 4'h0;
    localparam logic [3:0] BCP_PUNCT_RIGHT   = 4'hC;
    localparam logic [3:0] BCP_PUNCT_LEFT    = 4'h1;

    // ==========================================================
    // Carrier-position simulator
    localparam logic [3:0] BCP_SIM_PRESET    = 4'h8;
    localparam logic [3:0] BCP_SIM_TERMINAL  = 4'hF;
    localparam int         BCP_EARLY_MS      = 5;

    // ==========================================================
    // Reset values
    localparam logic [8:0] BCP_PINS_IDLE     = 9'h000;

    // Host register-style write/read path
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } bcp_host_req_t;

    // Sampled external optical and carrier levels
    typedef struct packed {
        logic carrierPos;
        logic printPosPulse;
        logic countPulse;
        logic fireWindowOk;
        logic atEndStop;
    } bcp_sense_t;

endpackage

// ### hw/bcp_sync.sv
// Two-flop synchroniser for a bundle of asynchronous levels.
// Assumes inputs come from pins outside the clock domain.
module bcp_sync
    import bcp_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire bcp_sense_t asyncIn,
    output bcp_sense_t      syncOut
);

    bcp_sense_t stage1;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            stage1  <= '0;
            syncOut <= '0;
        end
        else
        begin
            stage1  <= asyncIn;
            syncOut <= stage1;
        end
    end

endmodule

// ### dv/bcp_pin_fire_chk.sv
// Port-level checker for the pin fire block.
// Assumes one clock and a synchronous active-low reset.
module bcp_pin_fire_chk
    import bcp_pkg::*;
(
    input wire logic          clock,
    input wire logic          rst_n,
    input wire bcp_host_req_t hostReq,
    input wire logic          punctBackspace,
    input wire bcp_sense_t    senseIn,
    input wire logic [8:0]    pinFireGates_n,
    input wire logic          pinFireEnable_n,
    input wire logic          altRomSelect,
    input wire logic          requestMux,
    input wire logic          carrierError
);
    // ==========================================
    // Relations at the ports
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    wire flagsWr = hostReq.wr && hostReq.addr == BCP_FLAGS_PORT;
    rom_on_a: assert property (flagsWr && hostReq.wdata[4] |-> ##2 altRomSelect)
        else $error("punctuation ROM not selected");
    rom_off_a: assert property (flagsWr && !hostReq.wdata[4] |-> ##2 !altRomSelect)
        else $error("punctuation ROM still selected");
    pin_one_a: assert property (altRomSelect |-> pinFireGates_n[0])
        else $error("pin one gate open in punctuation mode");
    allow_off_a: assert property (flagsWr && !hostReq.wdata[0] |-> ##2 pinFireEnable_n)
        else $error("fire enable without print allowed");
    window_off_a: assert property (!senseIn.fireWindowOk [*5] |-> pinFireEnable_n)
        else $error("fire enable outside fire window");
    err_keep_a: assert property (carrierError |=> carrierError)
        else $error("carrier error dropped");
    err_cause_a: assert property ($rose(carrierError) |->
        $past(punctBackspace) || $past(punctBackspace, 2))
        else $error("carrier error without backspace");
    mux_real_a: assert property (senseIn.carrierPos [*5] |-> requestMux)
        else $error("request mux low while carrier high");
endmodule

bind bcp_pin_fire bcp_pin_fire_chk u_chk (.clock, .rst_n, .hostReq, .punctBackspace,
    .senseIn, .pinFireGates_n, .pinFireEnable_n, .altRomSelect, .requestMux, .carrierError);

// ### dv/bcp_host_model.sv
// Host processor model: writes the ports of the pin fire block.
// Assumes the block takes hostReq on the rising clock edge.
module bcp_host_model
    import bcp_pkg::*;
(
    input wire logic      clock,
    output bcp_host_req_t hostReq
);
    timeunit 1ns;
    timeprecision 1ns;
    initial hostReq = '0;
    // One-cycle write; mode in bit four, allow in bit zero
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        hostReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        hostReq.wr <= 1'b0;
    endtask
endmodule

// ### dv/tb_bcp_pin_fire.sv
// Self-checking bench for the pin fire block.
// Assumes a 10 MHz clock and the host model driving hostReq.
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin fails++; \
    $display("unexpected %s expected %h seen %h", n, e, s); end end
module tb_bcp_pin_fire
    import bcp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic          clock = 1'b0, rst_n = 1'b0, carrierGoRight = 1'b1, punctBackspace = 1'b0;
    bcp_sense_t    sense = '0;
    logic [8:0]    romLines = 9'h1FF;
    bcp_host_req_t hostReq;
    wire [8:0]     pinFireGates_n;
    wire [2:0]     punctRomAddr;
    wire           pinFireEnable_n, altRomSelect, requestMux, carrierError;
    int            fails = 0, n_tests = 0, cyc = 0, fires = 0;
    bcp_host_model host (.clock, .hostReq);
    bcp_pin_fire DUT (.clock, .rst_n, .hostReq, .carrierGoRight, .punctBackspace,
        .senseIn(sense), .romPinDriveLines(romLines), .pinFireGates_n, .pinFireEnable_n,
        .altRomSelect, .scanAddressLines(), .punctRomAddr, .requestMux, .carrierError);
    always #50 clock = ~clock;
    always @(negedge pinFireEnable_n) fires++;
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            fails++;
            conclude();
        end
    end
    // ==========================================
    // Helpers
    task automatic w(int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic pulses(int n);
        repeat (n)
        begin
            sense.printPosPulse <= 1'b1;
            sense.countPulse <= 1'b1;
            w(4);
            sense.printPosPulse <= 1'b0;
            sense.countPulse <= 1'b0;
            w(4);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // ==========================================
    // Scenarios
    task automatic t_fire(logic d);
        carrierGoRight <= d;
        sense.carrierPos <= 1'b1;
        sense.fireWindowOk <= 1'b1;
        host.wr(BCP_FLAGS_PORT, 8'h01);
        host.wr(BCP_PRINTER_PORT, 8'h00);
        w(6);
        fires = 0;
        `CHK("preset enable_n", 1'b1, pinFireEnable_n)
        pulses(13);
        `CHK("normal fires", 7, fires)
        host.wr(BCP_FLAGS_PORT, 8'h11);
        w(6);
        `CHK("punct addr", (d ? 3'h6 : 3'h0), punctRomAddr)
        `CHK("punct enable_n", 1'b0, pinFireEnable_n)
        `CHK("alt rom", 1'b1, altRomSelect)
        `CHK("pin one gate", 1'b1, pinFireGates_n[0])
        pulses(1);
        `CHK("punct gap", 1'b1, pinFireEnable_n)
        pulses(1);
        `CHK("punct second", 1'b0, pinFireEnable_n)
        host.wr(BCP_FLAGS_PORT, 8'h00);
        w(3);
        `CHK("alt rom off", 1'b0, altRomSelect)
        `CHK("allow off", 1'b1, pinFireEnable_n)
        $display("fire test done");
    endtask
    task automatic t_mux();
        sense.carrierPos <= 1'b0;
        w(6);
        `CHK("mux low", 1'b0, requestMux)
        pulses(6);
        `CHK("mux six edges", 1'b0, requestMux)
        pulses(1);
        `CHK("mux early", 1'b1, requestMux)
        $display("mux test done");
    endtask
    task automatic t_err(logic endStop);
        sense.atEndStop <= endStop;
        w(6);
        punctBackspace <= 1'b1;
        w(1);
        punctBackspace <= 1'b0;
        sense.atEndStop <= 1'b0;
        w(6);
        `CHK("carrier error", endStop, carrierError)
        $display("error test done");
    endtask
    initial
    begin
        w(10);
        rst_n <= 1'b1;
        w(2);
        `CHK("reset gates", 9'h1FF, pinFireGates_n)
        `CHK("reset enable_n", 1'b1, pinFireEnable_n)
        t_fire(1'b1);
        t_fire(1'b0);
        t_mux();
        t_err(1'b0);
        t_err(1'b1);
        rst_n <= 1'b0;
        w(2);
        rst_n <= 1'b1;
        w(2);
        `CHK("error cleared", 1'b0, carrierError)
        conclude();
    end
endmodule
